// >>> hdl/drv_regs_pkg.sv
// Constants and carrier types for the output driver protection register slice.
// Assumes a byte-wide register access port fed by the serial control bus front end.
package drv_regs_pkg;

   // Register address space per page
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int GAIN_W = 7;
   localparam int CM_W = 2;
   localparam int CM_LEVELS = 4;

   // Page numbers
   localparam logic [7:0] PAGE_ZERO = 8'h00;
   localparam logic [7:0] PAGE_ONE = 8'h01;

   // Offsets
   localparam logic [ADDR_W-1:0] OFS_PAGE_SELECT = 7'h00;
   localparam logic [ADDR_W-1:0] OFS_AMP_ERROR_CONTROL = 7'h1e;
   localparam logic [ADDR_W-1:0] OFS_HEADPHONE_DRIVER_CONTROL = 7'h1f;
   localparam logic [ADDR_W-1:0] OFS_PIN_GAIN_READBACK = 7'h75;

   // Reset values
   localparam logic [7:0] RST_PAGE_SELECT = 8'h00;
   localparam logic [7:0] RST_AMP_ERROR_CONTROL = 8'h00;
   localparam logic [7:0] RST_HEADPHONE_DRIVER_CONTROL = 8'h04;
   localparam logic [7:0] RST_PIN_GAIN_RESERVED = 8'h00;
   localparam logic [GAIN_W-1:0] RST_PIN_GAIN = 7'h00;

   // Field positions in amp_error_control
   localparam int POS_ERR_HP_KEEP = 1;
   localparam int POS_ERR_SPK_KEEP = 0;

   // Field positions in headphone_driver_control
   localparam int POS_HP_POWER_UP = 7;
   localparam int POS_HP_CM_LSB = 3;
   localparam int POS_HP_RESERVED_ONE = 2;
   localparam int POS_HP_SHUTDOWN_SEL = 1;
   localparam int POS_HP_SHORT_STATUS = 0;

   // Field position of the reserved bit in pin_gain_readback
   localparam int POS_GAIN_RESERVED = 7;

   // Gain code meanings: code 0 is +18 dB, half a decibel per step
   localparam logic [GAIN_W-1:0] GAIN_CODE_0DB = 7'h24;
   localparam logic [GAIN_W-1:0] GAIN_CODE_RESERVED = 7'h7f;

   // Register access request from the serial bus front end
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_s;

   // Register read answer
   typedef struct packed {
      logic valid;
      logic [DATA_W-1:0] data;
   } reg_rsp_s;

   // Raw short-circuit detector levels from the analog drivers
   typedef struct packed {
      logic hp;
      logic spk;
   } short_det_s;

endpackage

// >>> hdl/level_sync.sv
// Two-flop synchroniser bank for asynchronous detector levels.
// Assumes inputs are slow levels; multi-bit coherence is not needed.
`timescale 1ns/1ps
module level_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clk,               // Register clock
   input wire logic arst_n,            // Asynchronous reset, active low
   input wire logic [WIDTH-1:0] din,   // Asynchronous levels
   output logic [WIDTH-1:0] dout       // Synchronised levels
);

   // One pair of flops per bit; the first stage feeds only the second
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta_q;
         logic sync_q;
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= din[i];
               sync_q <= meta_q;
            end
         end
         assign dout[i] = sync_q;
      end
   endgenerate

endmodule

// >>> hdl/cm_level_decode.sv
// Decoder from the common-mode field to one-hot analog level selects.
// Assumes the analog side switches one reference tap per select line.
`timescale 1ns/1ps
module cm_level_decode (
   input wire logic clk,                                          // Register clock
   input wire logic arst_n,                                       // Asynchronous reset, active low
   input wire logic [drv_regs_pkg::CM_W-1:0] cm_field,            // Common-mode field
   output logic [drv_regs_pkg::CM_LEVELS-1:0] cm_select           // One-hot: 1.35, 1.5, 1.65, 1.8 V
);
   import drv_regs_pkg::*;

   logic [CM_LEVELS-1:0] sel_d;
   logic [CM_LEVELS-1:0] sel_q;

   // Code 00 picks 1.35 V up to code 11 for 1.8 V
   genvar i;
   generate
      for (i = 0; i < CM_LEVELS; i++) begin : g_lvl
         assign sel_d[i] = (cm_field == CM_W'(i));
      end
   endgenerate

   // Registered so the analog switch never sees decode glitches
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sel_q <= 4'h1;
      end else begin
         sel_q <= sel_d;
      end
   end

   assign cm_select = sel_q;

   a_cm_onehot_match: assert property (@(posedge clk) disable iff (!arst_n)
      1'b1 |=> (cm_select == (4'h1 << $past(cm_field))))
      else $error("Common-mode select does not match field");

endmodule

// >>> hdl/output_driver_protect_regs.sv
// Register slice for page select, pin-gain readback, and headphone and speaker
// short-circuit handling of the audio output stage.
// Assumes a serial control bus front end on the same clock issues one-cycle
// read and write strobes; detector levels arrive asynchronously from analog.
// Speaker power bits live outside this slice; it only raises a one-cycle clear request.
// The short status bit lags the detector pin by the two synchroniser clocks.
//
// Contract
// - Pin-gain readback returns 7-bit code; zero is +18 dB, half dB steps.
// - Address zero holds the page number used by later accesses; resets zero.
// - Error bit zero with protection active and shutdown selected clears headphone power bit on short.
// - Error bit one leaves headphone power bit unchanged on short.
// - Speaker error bit zero clears both speaker power bits on short.
// - Speaker error bit one keeps both speaker power bits unchanged on short.
// - Headphone driver powered while its power bit is one, except while held off by shutdown on short; resets zero.
// - Protection active, select zero: limit load current on short.
// - Protection active, select one: power headphone driver down on short.
// - Read-only status bit reads one while headphone short is present.
// - Two-bit common-mode field selects 1.35, 1.5, 1.65 or 1.8 V.
`timescale 1ns/1ps
module output_driver_protect_regs (
   input wire logic clk,                                    // Register clock, 250 MHz
   input wire logic arst_n,                                 // Asynchronous reset, active low
   input wire drv_regs_pkg::reg_req_s req,                  // Register read/write strobe
   output drv_regs_pkg::reg_rsp_s rsp,                      // Read answer, one cycle later
   input wire drv_regs_pkg::short_det_s short_raw,          // Analog short detectors
   input wire logic hp_protect_en,                          // Headphone short protection enabled
   input wire logic [drv_regs_pkg::GAIN_W-1:0] gain_code,   // Gain from volume_detect_pin converter
   input wire logic gain_valid,                             // Gain code strobe
   output logic [7:0] page,                                 // Selected register page
   output logic headphone_output_driver_en,                 // Headphone driver power
   output logic hp_current_limit,                           // Headphone current limit active
   output logic spk_power_clear,                            // Clear speaker_driver_left/right power bits
   output logic [drv_regs_pkg::CM_LEVELS-1:0] cm_select     // Common-mode level select
);
   import drv_regs_pkg::*;

   // Register state
   logic [7:0] page_q;
   logic [7:0] page_d;
   logic [7:0] err_ctl_q;
   logic [7:0] err_ctl_d;
   logic [7:1] hp_ctl_q;
   logic [7:1] hp_ctl_d;
   logic gain_rsv_q;
   logic gain_rsv_d;
   logic [GAIN_W-1:0] gain_q;
   logic [GAIN_W-1:0] gain_d;
   reg_rsp_s rsp_q;
   reg_rsp_s rsp_d;
   logic spk_clear_q;
   logic hp_short_prev_q;
   logic spk_short_prev_q;

   // Synchronised detector levels
   short_det_s short_sync;
   logic hp_short;
   logic spk_short;

   level_sync #(
      .WIDTH(2)
   ) u_short_sync (
      .clk(clk),
      .arst_n(arst_n),
      .din(short_raw),
      .dout(short_sync)
   );

   assign hp_short = short_sync.hp;
   assign spk_short = short_sync.spk;

   // Address decode against the current page
   wire on_page0 = (page_q == PAGE_ZERO);
   wire on_page1 = (page_q == PAGE_ONE);
   wire hit_page = (req.addr == OFS_PAGE_SELECT);
   wire hit_err = on_page1 && (req.addr == OFS_AMP_ERROR_CONTROL);
   wire hit_hp = on_page1 && (req.addr == OFS_HEADPHONE_DRIVER_CONTROL);
   wire hit_gain = on_page0 && (req.addr == OFS_PIN_GAIN_READBACK);
   wire wr_page = req.wr && hit_page;
   wire wr_err = req.wr && hit_err;
   wire wr_hp = req.wr && hit_hp;
   wire wr_gain = req.wr && hit_gain;

   // Nothing mapped here on this page; such reads answer zero
   wire hit_none = !(hit_page || hit_err || hit_hp || hit_gain);
   wire gain_rsv_in = req.wdata[POS_GAIN_RESERVED];

   // Short events and the responses they call for
   wire hp_short_rise = hp_short && !hp_short_prev_q;
   wire spk_short_rise = spk_short && !spk_short_prev_q;
   wire hp_keep = err_ctl_q[POS_ERR_HP_KEEP];
   wire spk_keep = err_ctl_q[POS_ERR_SPK_KEEP];
   wire hp_shutdown_sel = hp_ctl_q[POS_HP_SHUTDOWN_SEL];
   wire hp_auto_clear = hp_short_rise && hp_protect_en && hp_shutdown_sel && !hp_keep;
   wire spk_auto_clear = spk_short_rise && !spk_keep;

   // Page select: any page answers address zero
   assign page_d = wr_page ? req.wdata : page_q;

   // Error control: all bits plain storage
   assign err_ctl_d = wr_err ? req.wdata : err_ctl_q;

   // Headphone control: the hardware clear outranks a host write in the same cycle,
   // so a short never slips past a racing power-up write
   always_comb begin
      hp_ctl_d = hp_ctl_q;
      if (wr_hp) begin
         hp_ctl_d = req.wdata[7:1];
      end
      if (hp_auto_clear) begin
         hp_ctl_d[POS_HP_POWER_UP] = 1'b0;
      end
   end

   // Reserved readback bit is stored as written; gain tracks the converter
   assign gain_rsv_d = wr_gain ? req.wdata[POS_GAIN_RESERVED] : gain_rsv_q;
   assign gain_d = gain_valid ? gain_code : gain_q;

   // Read multiplexer; unmapped addresses read zero
   wire [7:0] rd_page = page_q;
   wire [7:0] rd_err = err_ctl_q;
   wire [7:0] rd_hp = {hp_ctl_q, hp_short};
   wire [7:0] rd_gain = {gain_rsv_q, gain_q};

   always_comb begin
      rsp_d.valid = req.rd;
      rsp_d.data = 8'h00;
      if (req.rd) begin
         if (hit_page) begin
            rsp_d.data = rd_page;
         end else if (hit_err) begin
            rsp_d.data = rd_err;
         end else if (hit_hp) begin
            rsp_d.data = rd_hp;
         end else if (hit_gain) begin
            rsp_d.data = rd_gain;
         end
      end
   end

   // Register updates
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         page_q <= RST_PAGE_SELECT;
         err_ctl_q <= RST_AMP_ERROR_CONTROL;
         hp_ctl_q <= RST_HEADPHONE_DRIVER_CONTROL[7:1];
         gain_rsv_q <= RST_PIN_GAIN_RESERVED[POS_GAIN_RESERVED];
         gain_q <= RST_PIN_GAIN;
      end else begin
         page_q <= page_d;
         err_ctl_q <= err_ctl_d;
         hp_ctl_q <= hp_ctl_d;
         gain_rsv_q <= gain_rsv_d;
         gain_q <= gain_d;
      end
   end

   // Read answer and edge history
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rsp_q <= '0;
         hp_short_prev_q <= 1'b0;
         spk_short_prev_q <= 1'b0;
         spk_clear_q <= 1'b0;
      end else begin
         rsp_q <= rsp_d;
         hp_short_prev_q <= hp_short;
         spk_short_prev_q <= spk_short;
         spk_clear_q <= spk_auto_clear;
      end
   end

   // Driver controls; shutdown also holds when the power bit is kept by choice
   wire hp_force_off = hp_protect_en && hp_shutdown_sel && hp_short;
   assign headphone_output_driver_en = hp_ctl_q[POS_HP_POWER_UP] && !hp_force_off;
   assign hp_current_limit = hp_protect_en && !hp_shutdown_sel && hp_short;
   assign spk_power_clear = spk_clear_q;
   assign page = page_q;
   assign rsp = rsp_q;

   cm_level_decode u_cm (
      .clk(clk),
      .arst_n(arst_n),
      .cm_field(hp_ctl_q[POS_HP_CM_LSB+1:POS_HP_CM_LSB]),
      .cm_select(cm_select)
   );

   // Sequences for the protection checks
   sequence s_hp_shut_event;
      hp_short_rise && hp_protect_en && hp_shutdown_sel;
   endsequence

   sequence s_spk_event;
      spk_short_rise;
   endsequence

   sequence s_hp_unprot_event;
      hp_short_rise && !hp_protect_en;
   endsequence

   a_page_write_takes: assert property (@(posedge clk) disable iff (!arst_n)
      wr_page |=> (page == $past(req.wdata)))
      else $error("Page select did not take written value");

   a_page_holds: assert property (@(posedge clk) disable iff (!arst_n)
      !wr_page |=> $stable(page))
      else $error("Page select changed without a write");

   a_gain_readback: assert property (@(posedge clk) disable iff (!arst_n)
      (req.rd && hit_gain && !gain_valid) |=> (rsp.valid && rsp.data[6:0] == gain_q))
      else $error("Pin gain readback wrong");

   a_hp_auto_clear: assert property (@(posedge clk) disable iff (!arst_n)
      (s_hp_shut_event and (!hp_keep)) |=> !hp_ctl_q[POS_HP_POWER_UP])
      else $error("Headphone power bit not cleared on short");

   a_hp_keep_bit: assert property (@(posedge clk) disable iff (!arst_n)
      (hp_short_rise && hp_keep && !wr_hp) |=> $stable(hp_ctl_q[POS_HP_POWER_UP]))
      else $error("Headphone power bit changed though kept");

   a_spk_clear_pulse: assert property (@(posedge clk) disable iff (!arst_n)
      (s_spk_event and (!spk_keep)) |=> spk_power_clear ##1 !spk_power_clear)
      else $error("Speaker clear pulse missing");

   a_spk_keep: assert property (@(posedge clk) disable iff (!arst_n)
      (spk_short_rise && spk_keep) |=> !spk_power_clear)
      else $error("Speaker clear while keep selected");

   a_hp_power_follow: assert property (@(posedge clk) disable iff (!arst_n)
      (!hp_force_off) |-> (headphone_output_driver_en == hp_ctl_q[POS_HP_POWER_UP]))
      else $error("Headphone driver does not follow power bit");

   a_hp_limit_mode: assert property (@(posedge clk) disable iff (!arst_n)
      (hp_protect_en && hp_short && !hp_shutdown_sel) |-> (hp_current_limit && !hp_force_off))
      else $error("Current limit not applied");

   a_hp_shutdown: assert property (@(posedge clk) disable iff (!arst_n)
      (hp_protect_en && hp_short && hp_shutdown_sel) |-> !headphone_output_driver_en)
      else $error("Headphone driver not shut down on short");

   a_status_live: assert property (@(posedge clk) disable iff (!arst_n)
      (req.rd && hit_hp) |=> (rsp.data[POS_HP_SHORT_STATUS] == $past(hp_short)))
      else $error("Short status bit not live");

   a_status_unlatched: assert property (@(posedge clk) disable iff (!arst_n)
      (req.rd && hit_hp && !hp_short) |=> (rsp.data[POS_HP_SHORT_STATUS] == 1'b0))
      else $error("Short status latched");

   a_rsp_timing: assert property (@(posedge clk) disable iff (!arst_n)
      req.rd |=> rsp.valid ##1 (rsp.valid == $past(req.rd)))
      else $error("Read answer timing wrong");

   // Storage checks: each writable field takes the bits that the host sent unless a short clears the power bit; the gain code follows the converter
   a_err_write_takes: assert property (@(posedge clk) disable iff (!arst_n)
      wr_err |=> (err_ctl_q == $past(req.wdata)))
      else $error("Error control did not take written value");

   a_hp_write_takes: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_hp && !hp_auto_clear) |=> ({hp_ctl_q, 1'b0} == ($past(req.wdata) & 8'hfe)))
      else $error("Headphone control did not take written value");

   a_gain_capture: assert property (@(posedge clk) disable iff (!arst_n)
      gain_valid |=> (gain_q == $past(gain_code)))
      else $error("Gain code not captured");

   a_gain_rsv_kept: assert property (@(posedge clk) disable iff (!arst_n)
      wr_gain |=> (gain_rsv_q == $past(gain_rsv_in)))
      else $error("Reserved gain bit not stored");

   a_rd_unmapped_zero: assert property (@(posedge clk) disable iff (!arst_n)
      (req.rd && hit_none) |=> (rsp.valid && rsp.data == 8'h00))
      else $error("Unmapped read not zero");

   // Protection checks with the enable low or the response fixed, and the status bit high during a short
   a_hp_unprot_keep: assert property (@(posedge clk) disable iff (!arst_n)
      (s_hp_unprot_event and (!wr_hp)) |=> $stable(hp_ctl_q[POS_HP_POWER_UP]))
      else $error("Headphone power bit cleared without protection");

   a_limit_needs_prot: assert property (@(posedge clk) disable iff (!arst_n)
      (!hp_protect_en) |-> (!hp_current_limit && !hp_force_off))
      else $error("Protection acted while disabled");

   a_shut_no_limit: assert property (@(posedge clk) disable iff (!arst_n)
      hp_shutdown_sel |-> !hp_current_limit)
      else $error("Current limit in shutdown mode");

   a_status_high: assert property (@(posedge clk) disable iff (!arst_n)
      (req.rd && hit_hp && hp_short) |=> (rsp.data[POS_HP_SHORT_STATUS] == 1'b1))
      else $error("Short status bit not set");

   // The speaker clear request is a single pulse and needs a fresh short
   a_spk_clear_cause: assert property (@(posedge clk) disable iff (!arst_n)
      (!spk_auto_clear) |=> !spk_power_clear)
      else $error("Speaker clear without a short");

   a_spk_clear_once: assert property (@(posedge clk) disable iff (!arst_n)
      spk_power_clear |=> !spk_power_clear)
      else $error("Speaker clear longer than one cycle");

endmodule

// >>> dv/host_model.sv
// Host processor model on the register port: one-cycle read and write strobes.
// Assumes the slice takes a strobe at a rising edge and answers a read one cycle later.
`timescale 1ns/1ps
module host_model (
   input wire logic clk,                     // Register clock
   output drv_regs_pkg::reg_req_s req,       // Strobes towards the slice
   input wire drv_regs_pkg::reg_rsp_s rsp,   // Read answer
   output logic hang                         // High when a read got no answer
);
   import drv_regs_pkg::*;
   logic [7:0] cur_page;

   // Idle bus; the host tracks the page itself so it can avoid reserved places
   initial begin
      req = '0;
      hang = 1'b0;
      cur_page = PAGE_ZERO;
   end

   // Reserved addresses of pages zero and one are never written
   function automatic logic reserved(input logic [ADDR_W-1:0] a);
      return (cur_page == PAGE_ZERO && a >= 7'h76) || (cur_page == PAGE_ONE && a >= 7'h01 && a <= 7'h1d);
   endfunction

   // Reserved bits are forced to their only legal value before the strobe
   task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (cur_page == PAGE_ZERO && a == OFS_PIN_GAIN_READBACK) v[POS_GAIN_RESERVED] = 1'b0;
      if (cur_page == PAGE_ONE && a == OFS_HEADPHONE_DRIVER_CONTROL) v[POS_HP_RESERVED_ONE] = 1'b1;
      if (!reserved(a)) begin
         @(posedge clk);
         req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
         @(posedge clk);
         req <= '0;
         if (a == OFS_PAGE_SELECT) cur_page = v;
      end
   endtask

   // Data is taken once valid is seen; a missing answer raises hang
   task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      req <= '0;
      #1;
      while (n < 4 && rsp.valid !== 1'b1) begin
         @(posedge clk);
         #1;
         n++;
      end
      d = (rsp.valid === 1'b1) ? rsp.data : 8'hxx;
      if (n == 4) hang = 1'b1;
   endtask
endmodule

// >>> dv/output_driver_protect_regs_test.sv
// Self-checking bench for the output driver protection register slice.
// Assumes the host model drives the register port; the bench drives detectors and gain.
`timescale 1ns/1ps
module output_driver_protect_regs_test;
   import drv_regs_pkg::*;
   logic clk, arst_n, hp_protect_en, gain_valid, hang, drv_en, limit, spk_clr;
   logic [GAIN_W-1:0] gain_code;
   logic [CM_LEVELS-1:0] cm_select;
   logic [7:0] page, rd;
   logic [1:0] pins;
   logic [7:0] rmid, raft;
   short_det_s short_raw;
   reg_req_s req;
   reg_rsp_s rsp;
   int n_mismatch = 0;
   int checks_done = 0;

   output_driver_protect_regs output_driver_protect_regs_i (.clk(clk), .arst_n(arst_n), .req(req), .rsp(rsp),
      .short_raw(short_raw), .hp_protect_en(hp_protect_en), .gain_code(gain_code), .gain_valid(gain_valid),
      .page(page), .headphone_output_driver_en(drv_en), .hp_current_limit(limit), .spk_power_clear(spk_clr),
      .cm_select(cm_select));
   host_model host_model_i (.clk(clk), .req(req), .rsp(rsp), .hang(hang));

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      host_model_i.read_reg(a, rd);
      chk(nm, exp, rd);
   endtask

   // A lost read answer ends the run at once
   always @(posedge hang) begin
      n_mismatch++;
      give_verdict();
   end

   task automatic reset_values();
      rd_chk("page_reg", OFS_PAGE_SELECT, 8'h00);
      rd_chk("gain_reg", OFS_PIN_GAIN_READBACK, 8'h00);
      host_model_i.write_reg(OFS_PAGE_SELECT, PAGE_ONE);
      rd_chk("err_reg", OFS_AMP_ERROR_CONTROL, 8'h00);
      rd_chk("hp_reg", OFS_HEADPHONE_DRIVER_CONTROL, 8'h04);
      chk("drv_en", 8'h00, {7'h00, drv_en});
      chk("cm_select", 8'h01, {4'h0, cm_select});
   endtask

   task automatic page_select();
      host_model_i.write_reg(OFS_PAGE_SELECT, 8'hff);
      rd_chk("page_reg", OFS_PAGE_SELECT, 8'hff);
      rd_chk("unmapped", OFS_HEADPHONE_DRIVER_CONTROL, 8'h00);
      host_model_i.write_reg(OFS_PAGE_SELECT, PAGE_ONE);
      rd_chk("reserved", 7'h05, 8'h00);
      chk("page", 8'h01, page);
   endtask

   task automatic cm_levels();
      for (int cm = 0; cm < 4; cm++) begin
         host_model_i.write_reg(OFS_HEADPHONE_DRIVER_CONTROL, {3'b000, 2'(cm), 3'b100});
         repeat (2) @(posedge clk);
         #1;
         chk("cm_select", 8'(1 << cm), {4'h0, cm_select});
      end
      host_model_i.write_reg(OFS_HEADPHONE_DRIVER_CONTROL, 8'h84);
      repeat (2) @(posedge clk);
      chk("drv_en", 8'h01, {7'h00, drv_en});
   endtask

   // Short on the headphone detector; pins and register seen during and after it
   task automatic hp_event(input logic [7:0] err, input logic [7:0] hp);
      host_model_i.write_reg(OFS_AMP_ERROR_CONTROL, err);
      host_model_i.write_reg(OFS_HEADPHONE_DRIVER_CONTROL, hp);
      @(posedge clk);
      short_raw.hp <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      pins = {drv_en, limit};
      host_model_i.read_reg(OFS_HEADPHONE_DRIVER_CONTROL, rmid);
      @(posedge clk);
      short_raw.hp <= 1'b0;
      repeat (5) @(posedge clk);
      host_model_i.read_reg(OFS_HEADPHONE_DRIVER_CONTROL, raft);
   endtask

   task automatic hp_shutdown_clear();
      hp_event(8'h00, 8'h86);
      chk("pins", 8'h00, {6'h00, pins});
      chk("hp_mid", 8'h07, rmid);
      chk("hp_after", 8'h06, raft);
   endtask

   task automatic hp_shutdown_keep();
      hp_event(8'h02, 8'h86);
      chk("pins", 8'h00, {6'h00, pins});
      chk("hp_mid", 8'h87, rmid);
      chk("hp_after", 8'h86, raft);
      chk("drv_en", 8'h01, {7'h00, drv_en});
   endtask

   task automatic hp_limit();
      hp_event(8'h00, 8'h85);
      chk("pins", 8'h03, {6'h00, pins});
      chk("hp_mid", 8'h85, rmid);
      chk("hp_after", 8'h84, raft);
   endtask

   // With protection off the driver stays up and nothing is cleared
   task automatic hp_unprotected();
      @(posedge clk);
      hp_protect_en <= 1'b0;
      hp_event(8'h00, 8'h86);
      chk("pins", 8'h02, {6'h00, pins});
      chk("hp_mid", 8'h87, rmid);
      chk("hp_after", 8'h86, raft);
      @(posedge clk);
      hp_protect_en <= 1'b1;
   endtask

   // Count clear pulses while the speaker short stands
   task automatic spk_case(input logic [7:0] err, input int exp_n);
      int n;
      n = 0;
      host_model_i.write_reg(OFS_AMP_ERROR_CONTROL, err);
      @(posedge clk);
      short_raw.spk <= 1'b1;
      repeat (8) begin
         @(posedge clk);
         #1;
         if (spk_clr === 1'b1) n++;
      end
      @(posedge clk);
      short_raw.spk <= 1'b0;
      repeat (4) @(posedge clk);
      chk("spk_clear_pulses", 8'(exp_n), 8'(n));
   endtask

   task automatic gain_readback();
      logic [GAIN_W-1:0] codes [3];
      codes = '{7'h00, GAIN_CODE_0DB, 7'h7e};
      host_model_i.write_reg(OFS_PAGE_SELECT, PAGE_ZERO);
      foreach (codes[i]) begin
         @(posedge clk);
         gain_code <= codes[i];
         gain_valid <= 1'b1;
         @(posedge clk);
         gain_valid <= 1'b0;
         rd_chk("gain_reg", OFS_PIN_GAIN_READBACK, {1'b0, codes[i]});
      end
      host_model_i.write_reg(OFS_PIN_GAIN_READBACK, 8'hff);
      rd_chk("gain_ro", OFS_PIN_GAIN_READBACK, 8'h7e);
   endtask

   // Main sequence
   initial begin
      arst_n = 1'b0;
      hp_protect_en = 1'b1;
      gain_valid = 1'b0;
      gain_code = '0;
      short_raw = '0;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      reset_values();
      page_select();
      cm_levels();
      hp_shutdown_clear();
      hp_shutdown_keep();
      hp_limit();
      hp_unprotected();
      spk_case(8'h00, 1);
      spk_case(8'h01, 0);
      gain_readback();
      give_verdict();
   end
endmodule
